// [design/rps_consts.svh]
// Register offsets, field positions, reset values of the port status bits block
// Assumes byte addresses on a plain strobe register port
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPS_OFS_STATUS 8'h00
`define RPS_OFS_CHANGE 8'h04
`define RPS_OFS_MASK   8'h08

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define RPS_BIT_ATTACH  0
`define RPS_BIT_ENABLE  1
`define RPS_BIT_SUSPEND 2
`define RPS_BIT_OVERCUR 3
`define RPS_BIT_RSTACT  4

// ----------------------------------------------------------------
// Change register fields
// ----------------------------------------------------------------
`define RPS_CHG_ATTACH  0
`define RPS_CHG_ENABLE  1
`define RPS_CHG_SUSPEND 2
`define RPS_CHG_RESET   3
`define RPS_CHG_W       4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPS_RST_CHANGE 4'h0
`define RPS_RST_MASK   4'h0
`define RPS_SYNC_RST   3'h0

`endif

// [design/rps_pkg.sv]
// Types of the port status bits block
// Assumes rps_consts.svh for numeric constants
package rps_pkg;

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RPS_DISABLED = 4'h1,
    RPS_ENABLED  = 4'h2,
    RPS_SUSPEND  = 4'h4,
    RPS_RESUMING = 4'h8
  } rps_state_e;

  typedef logic [3:0] rps_flags_t;

endpackage : rps_pkg

// [design/rps_port_state_bits.sv]
// Suspend, enable and connect status bits of one downstream root port
// Assumes one clock, pins asynchronous, other port logic on clk_sys
//
// How it works
// - A one written to the suspend position suspends the port; a zero does nothing.
// - The end of the resume interval clears suspended and raises the suspend change flag.
// - A suspend command to an unattached port only sets the attach change flag.
// - Reset completion and the controller resume state both clear suspended.
// - Overcurrent, disconnect, power loss or babble disable the port and set enable change.
// - A one written to the enable position enables the port; a zero does nothing.
// - An enable command to an unattached port only sets the attach change flag.
// - Reset completion and resume completion both leave the port enabled.
// - Status bit zero reads whether a device is attached.
// - A one written to bit zero disables the port; a zero does nothing.
// - No register write ever alters the attached status.
// - A port marked as holding a fixed device always reads attached.
// - Port power off clears enabled, suspended, reset activity and, unless the port holds a fixed device, attached.
// - A one written to the overcurrent position starts a resume; a zero does nothing.
//
// Decided for this implementation: strobed register access and the address map.

`timescale 1ns/100ps
`default_nettype none
`include "rps_consts.svh"

module rps_port_state_bits #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [DATA_W-1:0] regRdData,
  // Pins
  input  wire logic              attachPin,
  input  wire logic              overcurPin,
  // Rest of the port
  input  wire logic              fixedDevice,
  input  wire logic              portPowerOn,
  input  wire logic              portResetActive,
  input  wire logic              resetDone,
  input  wire logic              resumeDone,
  input  wire logic              babbleErr,
  input  wire logic              ctrlResumeState,
  // Port state outputs
  output logic                   deviceAttached,
  output logic                   portEnabled,
  output logic                   portSuspended,
  output logic                   resumeStart,
  output rps_pkg::rps_flags_t    changeFlags,
  // Interrupt
  output logic                   irq
);
  import rps_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DATA_W < 8) begin : gBadData
    $error("DATA_W must be at least 8");
  end
  if (ADDR_W < 4) begin : gBadAddr
    $error("ADDR_W must be at least 4");
  end
  if (`RPS_CHG_W > DATA_W) begin : gBadChg
    $error("DATA_W too narrow for the change flags");
  end

  localparam logic [ADDR_W-1:0] OFS_STATUS = ADDR_W'(`RPS_OFS_STATUS);
  localparam logic [ADDR_W-1:0] OFS_CHANGE = ADDR_W'(`RPS_OFS_CHANGE);
  localparam logic [ADDR_W-1:0] OFS_MASK   = ADDR_W'(`RPS_OFS_MASK);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  pinIn;
  logic [1:0]  pinStable_q;
  logic        attachLine;
  logic        overcurLine;
  logic        attachEff;
  logic        attachRead;
  logic        attachPrev_q;
  logic        disconnect;
  logic        wrStatus;
  logic        wrChange;
  logic        wrMask;
  logic        disableCmd;
  logic        enableCmd;
  logic        suspendCmd;
  logic        resumeCmd;
  logic        wasEnabled;
  logic        hwCause;
  logic        hwDrop;
  rps_state_e  state_q;
  rps_state_e  state_d;
  rps_flags_t  chgSet;
  rps_flags_t  chgClr;
  rps_flags_t  change_q;
  rps_flags_t  change_d;
  rps_flags_t  mask_q;
  logic        resumeGo;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pinIn = {overcurPin, attachPin};

  // A change counts once the last two flops agree, so a glitch of one cycle never lands
  for (genvar i = 0; i < 2; i++) begin : gSync
    logic [2:0] sync_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        sync_q <= `RPS_SYNC_RST;
      end else begin
        sync_q <= {sync_q[1:0], pinIn[i]};
      end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pinStable_q[i] <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
        pinStable_q[i] <= sync_q[2];
      end
    end
  end

  assign attachLine  = pinStable_q[0];
  assign overcurLine = pinStable_q[1];

  // ----------------------------------------------------------------
  // Attachment
  // ----------------------------------------------------------------
  assign attachEff  = portPowerOn & (fixedDevice | attachLine);
  assign attachRead = fixedDevice | attachEff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      attachPrev_q <= 1'b0;
    end else begin
      attachPrev_q <= attachEff;
    end
  end

  assign disconnect = attachPrev_q & ~attachEff;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wrStatus = regWrStb & (regAddr == OFS_STATUS);
  assign wrChange = regWrStb & (regAddr == OFS_CHANGE);
  assign wrMask   = regWrStb & (regAddr == OFS_MASK);

  assign disableCmd = wrStatus & regWrData[`RPS_BIT_ATTACH];
  assign enableCmd  = wrStatus & regWrData[`RPS_BIT_ENABLE];
  assign suspendCmd = wrStatus & regWrData[`RPS_BIT_SUSPEND];
  assign resumeCmd  = wrStatus & regWrData[`RPS_BIT_OVERCUR];

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  assign wasEnabled = (state_q != RPS_DISABLED);

  // Loss of attachment outranks every other cause
  always_comb begin
    state_d  = state_q;
    resumeGo = 1'b0;
    if (!attachEff) begin
      state_d = RPS_DISABLED;
    end else if (resetDone) begin
      state_d = RPS_ENABLED;
    end else if (overcurLine || babbleErr) begin
      state_d = RPS_DISABLED;
    end else begin
      case (state_q)
        RPS_DISABLED: begin
          if (disableCmd) begin
            state_d = RPS_DISABLED;
          end else if (suspendCmd) begin
            state_d = RPS_SUSPEND;
          end else if (enableCmd) begin
            state_d = RPS_ENABLED;
          end
        end
        RPS_ENABLED: begin
          if (disableCmd) begin
            state_d = RPS_DISABLED;
          end else if (suspendCmd) begin
            state_d = RPS_SUSPEND;
          end
        end
        RPS_SUSPEND: begin
          if (disableCmd) begin
            state_d = RPS_DISABLED;
          end else if (ctrlResumeState) begin
            state_d = RPS_ENABLED;
          end else if (resumeCmd) begin
            state_d  = RPS_RESUMING;
            resumeGo = 1'b1;
          end
        end
        RPS_RESUMING: begin
          if (disableCmd) begin
            state_d = RPS_DISABLED;
          end else if (resumeDone || ctrlResumeState) begin
            state_d = RPS_ENABLED;
          end
        end
        default: begin
          state_d = RPS_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RPS_DISABLED;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Hardware disable
  // ----------------------------------------------------------------
  // A hardware cause beside a disable write still counts as a drop
  assign hwCause = ~attachEff | (~resetDone & (overcurLine | babbleErr));
  assign hwDrop  = wasEnabled & hwCause;

  // ----------------------------------------------------------------
  // Change flags
  // ----------------------------------------------------------------

  always_comb begin
    chgSet = '0;
    chgSet[`RPS_CHG_ATTACH]  = (attachPrev_q != attachEff)
                             | ((suspendCmd | enableCmd) & ~attachEff);
    chgSet[`RPS_CHG_ENABLE]  = hwDrop | (wasEnabled & disconnect);
    chgSet[`RPS_CHG_SUSPEND] = (state_q == RPS_RESUMING) & resumeDone & attachEff;
    chgSet[`RPS_CHG_RESET]   = resetDone;
  end

  assign chgClr   = wrChange ? regWrData[`RPS_CHG_W-1:0] : '0;
  // A set in the same cycle as a clear wins, so no event is lost
  assign change_d = (change_q & ~chgClr) | chgSet;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      change_q <= `RPS_RST_CHANGE;
    end else begin
      change_q <= change_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `RPS_RST_MASK;
    end else if (wrMask) begin
      mask_q <= regWrData[`RPS_CHG_W-1:0];
    end
  end

  // Built from the next flag value so the interrupt keeps pace with the flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(change_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data stand for one cycle only, then fall back to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRdStb) begin
      regRdData <= '0;
      case (regAddr)
        OFS_STATUS: begin
          regRdData[`RPS_BIT_ATTACH]  <= attachRead;
          regRdData[`RPS_BIT_ENABLE]  <= wasEnabled;
          regRdData[`RPS_BIT_SUSPEND] <= (state_q == RPS_SUSPEND)
                                       | (state_q == RPS_RESUMING);
          regRdData[`RPS_BIT_OVERCUR] <= overcurLine;
          regRdData[`RPS_BIT_RSTACT]  <= portResetActive & portPowerOn;
        end
        OFS_CHANGE: begin
          regRdData[`RPS_CHG_W-1:0] <= change_q;
        end
        OFS_MASK: begin
          regRdData[`RPS_CHG_W-1:0] <= mask_q;
        end
        default: begin
          regRdData <= '0;
        end
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Port state outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      deviceAttached <= 1'b0;
      portEnabled    <= 1'b0;
      portSuspended  <= 1'b0;
    end else begin
      deviceAttached <= attachRead;
      portEnabled    <= (state_d != RPS_DISABLED);
      portSuspended  <= (state_d == RPS_SUSPEND) | (state_d == RPS_RESUMING);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resumeStart <= 1'b0;
    end else begin
      resumeStart <= resumeGo;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      changeFlags <= `RPS_RST_CHANGE;
    end else begin
      changeFlags <= change_d;
    end
  end

endmodule : rps_port_state_bits

`default_nettype wire

// [design/rps_port_state_bits_end.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [tb/rps_port_state_bits_sva.sv]
// Concurrent checks on the ports of the root port status bits block
// Assumes one clock domain and the constants of rps_consts.svh
`timescale 1ns/100ps
`default_nettype none
`include "rps_consts.svh"

module rps_port_state_bits_sva #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_n,
  // Register port
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic [DATA_W-1:0]   regWrData,
  input wire logic                regWrStb,
  // Port inputs
  input wire logic                attachPin,
  input wire logic                fixedDevice,
  input wire logic                portPowerOn,
  input wire logic                resetDone,
  input wire logic                babbleErr,
  // Port state
  input wire logic                deviceAttached,
  input wire logic                portEnabled,
  input wire logic                portSuspended,
  input wire logic                resumeStart,
  input wire rps_pkg::rps_flags_t changeFlags
);
  import rps_pkg::*;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic       stWr;
  logic       resumeWr_q;
  logic [3:0] clrWr_q;
  assign stWr = regWrStb && (regAddr == ADDR_W'(`RPS_OFS_STATUS));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resumeWr_q <= 1'b0;
      clrWr_q    <= 4'h0;
    end else begin
      resumeWr_q <= stWr && regWrData[`RPS_BIT_OVERCUR];
      clrWr_q    <= (regWrStb && regAddr == ADDR_W'(`RPS_OFS_CHANGE)) ? regWrData[3:0] : 4'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_no_att;
    stWr && (regWrData[`RPS_BIT_ENABLE] || regWrData[`RPS_BIT_SUSPEND]) && !portPowerOn
      && !$past(portPowerOn) |=> !portEnabled && !portSuspended && changeFlags[`RPS_CHG_ATTACH];
  endproperty
  a_no_att: assert property (p_no_att)
    else $error("command to unattached port took effect");
  property p_dis;
    stWr && regWrData[`RPS_BIT_ATTACH] && !resetDone |=> !portEnabled && !portSuspended;
  endproperty
  a_dis: assert property (p_dis)
    else $error("disable command ignored");
  property p_res_end;
    $rose(changeFlags[`RPS_CHG_SUSPEND]) |-> portEnabled && !portSuspended;
  endproperty
  a_res_end: assert property (p_res_end)
    else $error("resume end left port suspended");
  property p_rst_end;
    resetDone && deviceAttached && portPowerOn
      |=> portEnabled && !portSuspended && changeFlags[`RPS_CHG_RESET];
  endproperty
  a_rst_end: assert property (p_rst_end)
    else $error("reset completion mishandled");
  property p_res_start;
    resumeStart |-> resumeWr_q && portSuspended ##1 !resumeStart;
  endproperty
  a_res_start: assert property (p_res_start)
    else $error("resume start without command");
  property p_sticky;
    (~changeFlags & $past(changeFlags) & ~clrWr_q) == 4'h0;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("change flag lost without clear");
  property p_attach;
    (attachPin && portPowerOn)[*8] |-> deviceAttached;
  endproperty
  a_attach: assert property (p_attach)
    else $error("attached status does not follow pin");
  property p_babble;
    babbleErr && portEnabled && !resetDone |=> !portEnabled && changeFlags[`RPS_CHG_ENABLE];
  endproperty
  a_babble: assert property (p_babble)
    else $error("babble did not disable port");
  property p_fixed;
    fixedDevice |=> deviceAttached;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed device not read as attached");
  property p_pwr;
    (!portPowerOn)[*3] |-> !portEnabled && !portSuspended;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("port active without power");
endmodule : rps_port_state_bits_sva

bind rps_port_state_bits rps_port_state_bits_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .clk_sys, .rst_n, .regAddr, .regWrData, .regWrStb, .attachPin, .fixedDevice,
  .portPowerOn, .resetDone, .babbleErr, .deviceAttached, .portEnabled,
  .portSuspended, .resumeStart, .changeFlags);
`default_nettype wire

// [tb/rps_usb_dev.sv]
// Model of the device plugged into the downstream port
// Assumes the bench commands plug-in and short circuit on clk_sys
`timescale 1ns/100ps
`default_nettype none

module rps_usb_dev (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Bench commands
  input  wire logic plugIn,
  input  wire logic shortCkt,
  // Pins
  output logic      attachPin,
  output logic      overcurPin
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      attachPin  <= 1'b0;
      overcurPin <= 1'b0;
    end else begin
      attachPin  <= plugIn;
      overcurPin <= shortCkt;
    end
  end
endmodule : rps_usb_dev
`default_nettype wire

// [tb/rps_port_state_bits_tb.sv]
// Self-checking bench for the root port status bits
// Assumes the design, the checker and the device model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "rps_consts.svh"

module rps_port_state_bits_tb;
  import rps_pkg::*;
  localparam logic [7:0] ST = `RPS_OFS_STATUS, CH = `RPS_OFS_CHANGE, MK = `RPS_OFS_MASK;
  logic        clk_sys = 1'b0, rst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic        attachPin, overcurPin, plugIn = 1'b0, shortCkt = 1'b0;
  logic        fixedDevice = 1'b0, portPowerOn = 1'b1, portResetActive = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        deviceAttached, portEnabled, portSuspended, resumeStart, irq;
  rps_flags_t  changeFlags;
  int          errTotal = 0, nTests = 0, tNum = 0;

  always #2.5 clk_sys = ~clk_sys;

  rps_usb_dev u_dev (.clk_sys, .rst_n, .plugIn, .shortCkt, .attachPin, .overcurPin);
  rps_port_state_bits u_dut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .attachPin, .overcurPin, .fixedDevice, .portPowerOn,
    .portResetActive, .resetDone(ev[0]), .resumeDone(ev[1]), .babbleErr(ev[2]),
    .ctrlResumeState(ev[3]), .deviceAttached, .portEnabled, .portSuspended,
    .resumeStart, .changeFlags, .irq);

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk_sys);
    regWrStb  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(negedge clk_sys);
    chk("regRdData", e, regRdData);
  endtask : rd
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask : pulse
  task automatic done;
    tNum++;
    $display("test %0d finished", tNum);
  endtask : done
  task automatic finalReport;
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finalReport

  initial begin
    #200us;
    errTotal++;
    finalReport;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ST, 32'h0);
    rd(CH, 32'h0);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h0);
    @(posedge clk_sys) portResetActive <= 1'b1;
    rd(ST, 32'h10);
    @(posedge clk_sys) portResetActive <= 1'b0;
    wr(MK, 32'hF);
    rd(MK, 32'hF);
    done;
    wr(ST, 32'h2);
    rd(CH, 32'h1);
    chk("irq", 32'h1, irq);
    wr(MK, 32'h0);
    rd(MK, 32'h0);
    chk("irq", 32'h0, irq);
    wr(MK, 32'hF);
    wr(CH, 32'h1);
    rd(CH, 32'h0);
    chk("irq", 32'h0, irq);
    wr(ST, 32'h4);
    rd(ST, 32'h0);
    rd(CH, 32'h1);
    wr(CH, 32'h1);
    done;
    @(posedge clk_sys) plugIn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(ST, 32'h1);
    rd(CH, 32'h1);
    wr(CH, 32'h1);
    wr(ST, 32'h2);
    rd(ST, 32'h3);
    wr(ST, 32'h0);
    rd(ST, 32'h3);
    wr(ST, 32'h1);
    rd(ST, 32'h1);
    rd(CH, 32'h0);
    done;
    wr(ST, 32'h2);
    wr(ST, 32'h4);
    rd(ST, 32'h7);
    wr(ST, 32'h8);
    @(negedge clk_sys) chk("resumeStart", 32'h1, resumeStart);
    pulse(4'h2);
    rd(ST, 32'h3);
    rd(CH, 32'h4);
    wr(CH, 32'h4);
    wr(ST, 32'h4);
    pulse(4'h8);
    rd(ST, 32'h3);
    wr(ST, 32'h4);
    pulse(4'h1);
    rd(ST, 32'h3);
    rd(CH, 32'h8);
    wr(CH, 32'h8);
    done;
    pulse(4'h4);
    rd(ST, 32'h1);
    repeat (20) @(posedge clk_sys);
    wr(CH, 32'h0);
    rd(CH, 32'h2);
    wr(CH, 32'h2);
    rd(CH, 32'h0);
    wr(ST, 32'h2);
    @(posedge clk_sys) shortCkt <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(ST, 32'h9);
    rd(CH, 32'h2);
    @(posedge clk_sys) shortCkt <= 1'b0;
    wr(CH, 32'h2);
    done;
    @(posedge clk_sys) fixedDevice <= 1'b1;
    plugIn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(ST, 32'h1);
    wr(ST, 32'h1);
    rd(ST, 32'h1);
    @(posedge clk_sys) plugIn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    @(posedge clk_sys) fixedDevice <= 1'b0;
    wr(CH, 32'hF);
    wr(ST, 32'h2);
    rd(ST, 32'h3);
    wr(ST, 32'h4);
    wr(ST, 32'h8);
    rd(ST, 32'h7);
    pulse(4'h8);
    rd(ST, 32'h3);
    rd(CH, 32'h0);
    wr(ST, 32'h4);
    wr(ST, 32'h8);
    wr(ST, 32'h1);
    rd(ST, 32'h1);
    rd(CH, 32'h0);
    wr(ST, 32'h2);
    rd(ST, 32'h3);
    @(posedge clk_sys) portPowerOn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(ST, 32'h0);
    wr(ST, 32'h2);
    rd(ST, 32'h0);
    rd(CH, 32'h3);
    done;
    finalReport;
  end
endmodule : rps_port_state_bits_tb
`default_nettype wire
